/* File: cerr_pkg.sv */
package cerr_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] VECTOR_ENTRY_OFS = 12'h2f0;
    localparam logic [31:0] VECTOR_ENTRY_RST = 32'h0001_0000;
    localparam logic [11:0] SAVE_BASE_IDX = 12'h180;
    localparam logic [11:0] BANK_CTL2_BASE = 12'h280;
    localparam logic [11:0] BANK_STATUS_BASE = 12'h401;
    localparam logic [11:0] BANK_ADDR_BASE = 12'h402;
    localparam logic [11:0] LEGACY_ADDR_IDX = 12'h000;
    localparam logic [11:0] LEGACY_TYPE_IDX = 12'h001;
    localparam logic [11:0] GLOBAL_CAP_IDX = 12'h179;
    localparam int SAVE_COUNT = 18;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int VEC_LSB = 0;
    localparam int MODE_LSB = 8;
    localparam int DSTAT_BIT = 12;
    localparam int MASK_BIT = 16;
    localparam int THR_MSB = 14;
    localparam int CEN_BIT = 30;
    localparam int CNT_LSB = 38;
    localparam int CAP_CTL2_BIT = 10;
    localparam int CAP_TES_BIT = 11;
    localparam logic [7:0] MIN_VECTOR = 8'h10;
    localparam logic [2:0] MODE_FIXED = 3'h0;
    localparam logic [2:0] MODE_SMI = 3'h2;
    localparam logic [2:0] MODE_NMI = 3'h4;
    localparam logic [31:0] ENTRY_WMASK = 32'h0001_07ff;
    localparam logic [7:0] ERR_ILLEGAL_VEC = 8'h40;
endpackage

/* File: save_state_mem.sv */
`timescale 1ns/1ps
module save_state_mem
    import cerr_pkg::*;
#(
    parameter int WIDTH = 64,
    parameter int DEPTH = 18
) (
    input wire logic clk,
    input wire logic hardRst,
    input wire logic capture,
    input wire logic [WIDTH*DEPTH-1:0] captureData,
    input wire logic clrWrite,
    input wire logic [4:0] rdIdx,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [WIDTH-1:0] rdData_d;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            if (capture) begin
                mem_d[i] = captureData[i*WIDTH +: WIDTH];
            end else if (clrWrite && rdIdx == 5'(i)) begin
                mem_d[i] = '0;
            end else begin
                mem_d[i] = mem_q[i];
            end
        end
        rdData_d = (int'(rdIdx) < DEPTH) ? mem_q[rdIdx] : '0;
    end

    // Hardware reset clears every entry and a zero write clears one; soft reset never reaches here
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (hardRst) begin
                mem_q[i] <= '0;
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
        rdData <= hardRst ? '0 : rdData_d;
    end
endmodule

/* File: bank_threshold.sv */
`timescale 1ns/1ps
module bank_threshold
    import cerr_pkg::*;
#(
    parameter bit HAS_CORRECTED_ERROR_INTERRUPT = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [31:0] wrData,
    input wire logic [14:0] errCount,
    input wire logic countUpdate,
    output logic [31:0] ctlValue,
    output logic overflow
);
    logic [14:0] thr_q, thr_d;
    logic en_q, en_d;
    logic ovf_q, ovf_d;

    always_comb begin
        thr_d = thr_q;
        en_d = en_q;
        if (wrEn && HAS_CORRECTED_ERROR_INTERRUPT) begin
            thr_d = wrData[THR_MSB:0];
            en_d = wrData[CEN_BIT];
        end
        // Pulse only on the update that lands on the threshold
        ovf_d = HAS_CORRECTED_ERROR_INTERRUPT && countUpdate && thr_q != '0 && errCount == thr_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            thr_q <= '0;
            en_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            thr_q <= thr_d;
            en_q <= en_d;
            ovf_q <= ovf_d;
        end
    end

    assign ctlValue = {1'b0, en_q, 15'h0, thr_q};
    assign overflow = ovf_q && en_q;
endmodule

/* File: corrected_error_signaling.sv */
`timescale 1ns/1ps
// Summary of operation
// - On machine-check error, copy GPRs, flags and IP into saved-state registers.
// - Saved-state registers readable; non-zero write raises general-protection fault.
// - Saved-state cleared by hardware reset, kept across soft init reset.
// - Legacy type/address registers alias one bank's status and address.
// - Capability bit 11 reads 1 when threshold status supported.
// - Cache health counts lines with repeated corrections, not events.
// - Green at or below fixed threshold, yellow above.
// - Corrected-error interrupt disabled after reset; enabled per bank when bit 30 set.
// - Machine-check enable bit and bank logging control do not affect it.
// - Threshold bits 14:0 read back if supported, else zero.
// - Enable bit 30 reads back 1 when supported, else 0.
// - Vector entry sits at offset 2F0H; delivery configured by writing it.
// - Shared-subsystem errors interrupt all sharing logical processors.
// - System-level errors never produce this interrupt.
// - Vector bits 7:0; values 0-15 log illegal-vector error.
// - Mode 000B fixed vector delivery, 010B system-management interrupt.
// - Mode 100B delivers NMI, vector ignored.
// - Modes 101B and 111B unsupported; other codes reserved.
// - Bit 12 set while delivered but not accepted.
// - Mask bit 16 resets to 1, inhibits, never set by hardware.
// - Bits 31:17, 15:13, 11 reserved, no function.
// - Overflow event when bank error count equals programmed threshold.
// - All bank control registers reset to zero.
module corrected_error_signaling
    import cerr_pkg::*;
#(
    parameter int BANKS = 4,
    parameter int LEGACY_BANK = 0,
    parameter logic [BANKS-1:0] BANK_CORRECTED_ERROR_INTERRUPT = '1,
    parameter int THREADS = 2,
    parameter bit TES_SUPPORTED = 1'b1,
    parameter int HEALTH_THRESHOLD = 4,
    parameter logic [7:0] BANK_COUNT_ID = 8'h04 // Arbitrary count field
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic softInit,
    // Model register port
    input wire logic msrWrEn,
    input wire logic msrRdEn,
    input wire logic [11:0] msrIdx,
    input wire logic [63:0] msrWrData,
    // Local interrupt controller port
    input wire logic apicWrEn,
    input wire logic apicRdEn,
    input wire logic [11:0] apicOfs,
    input wire logic [31:0] apicWrData,
    // Machine-check capture
    input wire logic mcError,
    input wire logic [64*18-1:0] archState,
    // Corrected-error sources
    input wire logic [BANKS-1:0] countUpdate,
    input wire logic [BANKS*15-1:0] errCount,
    input wire logic [BANKS-1:0] sysLevelErr,
    input wire logic [BANKS-1:0] sharedErr,
    input wire logic [BANKS*64-1:0] bankStatus,
    input wire logic [BANKS*64-1:0] bankAddr,
    // Cache health
    input wire logic repeatLine,
    input wire logic healthClear,
    // Delivery handshake
    input wire logic intAccept,
    output logic [63:0] msrRdData,
    output logic msrRdValid,
    output logic gpFault,
    output logic [31:0] apicRdData,
    output logic apicRdValid,
    output logic [7:0] apicErrStatus,
    output logic [THREADS-1:0] fixedReq,
    output logic [7:0] fixedVector,
    output logic [THREADS-1:0] smiReq,
    output logic [THREADS-1:0] nmiReq,
    output logic healthYellow
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic inRange(input logic [11:0] idx, input logic [11:0] base,
                                     input int n, input int stride);
        logic [11:0] diff;
        diff = idx - base;
        return idx >= base && int'(diff) < n * stride && (int'(diff) % stride) == 0;
    endfunction

    typedef enum logic [2:0] {
        DLV_IDLE = 3'b001,
        DLV_SEND = 3'b010,
        DLV_WAIT = 3'b100
    } dlv_t;

    // ----------------------------------------
    // Saved-state registers
    // ----------------------------------------
    logic saveHit, saveWrite, saveClr;
    logic [4:0] saveIdx;
    logic [63:0] saveData;

    always_comb begin
        saveHit = inRange(msrIdx, SAVE_BASE_IDX, SAVE_COUNT, 1);
        saveIdx = 5'(msrIdx - SAVE_BASE_IDX);
        saveWrite = msrWrEn && saveHit;
        saveClr = saveWrite && msrWrData == '0;
    end

    save_state_mem #(.WIDTH(64), .DEPTH(SAVE_COUNT)) u_save (
        .clk(clk),
        .hardRst(sys_rst),
        .capture(mcError),
        .captureData(archState),
        .clrWrite(saveClr),
        .rdIdx(saveIdx),
        .rdData(saveData)
    );

    // ----------------------------------------
    // Per-bank control
    // ----------------------------------------
    logic [BANKS-1:0] bankWr, bankOvf;
    logic [31:0] bankCtl [BANKS];

    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_comb begin
            bankWr[b] = msrWrEn && msrIdx == BANK_CTL2_BASE + 12'(b);
        end
        bank_threshold #(.HAS_CORRECTED_ERROR_INTERRUPT(BANK_CORRECTED_ERROR_INTERRUPT[b])) u_bank (
            .clk(clk),
            .sys_rst(sys_rst),
            .wrEn(bankWr[b]),
            .wrData(msrWrData[31:0]),
            .errCount(errCount[b*15 +: 15]),
            .countUpdate(countUpdate[b] && !sysLevelErr[b]),
            .ctlValue(bankCtl[b]),
            .overflow(bankOvf[b])
        );
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    logic [63:0] msrRdData_d;
    logic gpFault_d;
    logic [63:0] capValue;

    always_comb begin
        capValue = '0;
        capValue[7:0] = BANK_COUNT_ID;
        capValue[CAP_CTL2_BIT] = 1'b1;
        capValue[CAP_TES_BIT] = TES_SUPPORTED;
        msrRdData_d = '0;
        if (saveHit) begin
            msrRdData_d = saveData;
        end else if (msrIdx == GLOBAL_CAP_IDX) begin
            msrRdData_d = capValue;
        end else if (msrIdx == LEGACY_TYPE_IDX) begin
            msrRdData_d = bankStatus[LEGACY_BANK*64 +: 64];
        end else if (msrIdx == LEGACY_ADDR_IDX) begin
            msrRdData_d = bankAddr[LEGACY_BANK*64 +: 64];
        end else begin
            for (int b = 0; b < BANKS; b++) begin
                if (msrIdx == BANK_CTL2_BASE + 12'(b)) begin
                    msrRdData_d = {32'h0, bankCtl[b]};
                end
                if (msrIdx == BANK_STATUS_BASE + 12'(4 * b)) begin
                    msrRdData_d = bankStatus[b*64 +: 64];
                end
                if (msrIdx == BANK_ADDR_BASE + 12'(4 * b)) begin
                    msrRdData_d = bankAddr[b*64 +: 64];
                end
            end
        end
        gpFault_d = saveWrite && msrWrData != '0;
    end

    // ----------------------------------------
    // Vector table entry
    // ----------------------------------------
    logic [31:0] entry_q, entry_d;
    logic [7:0] errStat_q, errStat_d;
    logic entryWr;
    logic [2:0] mode;
    logic [7:0] vecField;
    logic dstatNext;

    always_comb begin
        entryWr = apicWrEn && apicOfs == VECTOR_ENTRY_OFS;
        entry_d = entry_q;
        errStat_d = errStat_q;
        if (entryWr) begin
            // Delivery status is hardware-owned; reserved bits drop
            entry_d = apicWrData & ENTRY_WMASK;
            if (apicWrData[7:0] < MIN_VECTOR) begin
                errStat_d = errStat_q | ERR_ILLEGAL_VEC;
            end
        end
        entry_d[DSTAT_BIT] = dstatNext;
        mode = entry_q[MODE_LSB +: 3];
        vecField = entry_q[VEC_LSB +: 8];
    end

    // ----------------------------------------
    // Delivery sequencer
    // ----------------------------------------
    dlv_t state_q, state_d;
    logic pend_q, pend_d;
    logic share_q, share_d;
    logic [THREADS-1:0] fixedReq_d, smiReq_d, nmiReq_d, targets;
    logic [7:0] fixedVector_d;
    logic modeOk;

    always_comb begin
        modeOk = mode == MODE_FIXED || mode == MODE_SMI || mode == MODE_NMI;
        pend_d = pend_q || (|bankOvf);
        share_d = share_q || (|(bankOvf & sharedErr));
        state_d = state_q;
        fixedReq_d = '0;
        smiReq_d = '0;
        nmiReq_d = '0;
        fixedVector_d = fixedVector;
        // Shared source reaches every sharing thread, else thread 0 only
        targets = share_q ? '1 : THREADS'(1);
        case (state_q)
            DLV_IDLE: begin
                if (pend_q && !entry_q[MASK_BIT] && modeOk) begin
                    state_d = DLV_SEND;
                end
            end
            DLV_SEND: begin
                pend_d = |bankOvf;
                share_d = |(bankOvf & sharedErr);
                state_d = DLV_WAIT;
                case (mode)
                    MODE_FIXED: begin
                        fixedReq_d = targets;
                        fixedVector_d = vecField;
                    end
                    MODE_SMI: smiReq_d = targets;
                    MODE_NMI: nmiReq_d = targets;
                    default: state_d = DLV_IDLE;
                endcase
            end
            DLV_WAIT: begin
                if (intAccept) begin
                    state_d = DLV_IDLE;
                end
            end
            default: state_d = DLV_IDLE;
        endcase
        // Set from the request until the core accepts
        dstatNext = state_d == DLV_WAIT;
    end

    // ----------------------------------------
    // Cache health
    // ----------------------------------------
    logic [15:0] lineCnt_q, lineCnt_d;

    always_comb begin
        lineCnt_d = lineCnt_q;
        if (healthClear) begin
            // A line reported in the clearing cycle still counts
            lineCnt_d = {15'h0, repeatLine};
        end else if (repeatLine && lineCnt_q != 16'hffff) begin
            lineCnt_d = lineCnt_q + 16'h1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            entry_q <= VECTOR_ENTRY_RST;
            errStat_q <= '0;
            state_q <= DLV_IDLE;
            pend_q <= 1'b0;
            share_q <= 1'b0;
            lineCnt_q <= '0;
            msrRdData <= '0;
            msrRdValid <= 1'b0;
            gpFault <= 1'b0;
            apicRdData <= '0;
            apicRdValid <= 1'b0;
            apicErrStatus <= '0;
            fixedReq <= '0;
            fixedVector <= '0;
            smiReq <= '0;
            nmiReq <= '0;
            healthYellow <= 1'b0;
        end else begin
            entry_q <= entry_d;
            errStat_q <= errStat_d;
            state_q <= state_d;
            pend_q <= pend_d;
            share_q <= share_d;
            lineCnt_q <= lineCnt_d;
            msrRdData <= msrRdEn ? msrRdData_d : '0;
            msrRdValid <= msrRdEn;
            gpFault <= gpFault_d;
            apicRdData <= (apicRdEn && apicOfs == VECTOR_ENTRY_OFS) ? entry_q : '0;
            apicRdValid <= apicRdEn;
            apicErrStatus <= errStat_d;
            fixedReq <= fixedReq_d;
            fixedVector <= fixedVector_d;
            smiReq <= smiReq_d;
            nmiReq <= nmiReq_d;
            healthYellow <= int'(lineCnt_d) > HEALTH_THRESHOLD;
        end
    end

    // Soft init keeps all state here; it only matters to the core
    logic unusedSoft;
    assign unusedSoft = softInit;
endmodule

/* File: cerr_checker.sv */
`timescale 1ns/1ps
module cerr_checker
    import cerr_pkg::*;
#(
    parameter bit TES_SUPPORTED = 1'b1,
    parameter int THREADS = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic msrWrEn,
    input wire logic msrRdEn,
    input wire logic [11:0] msrIdx,
    input wire logic [63:0] msrWrData,
    input wire logic apicWrEn,
    input wire logic apicRdEn,
    input wire logic [11:0] apicOfs,
    input wire logic [31:0] apicWrData,
    input wire logic [63:0] msrRdData,
    input wire logic msrRdValid,
    input wire logic gpFault,
    input wire logic [31:0] apicRdData,
    input wire logic apicRdValid,
    input wire logic [7:0] apicErrStatus,
    input wire logic [THREADS-1:0] fixedReq,
    input wire logic [THREADS-1:0] smiReq,
    input wire logic [THREADS-1:0] nmiReq
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic badWr;
    logic entryRd;
    assign badWr = msrWrEn && (msrIdx - SAVE_BASE_IDX) < 12'h012 && msrWrData != 64'h0;
    assign entryRd = apicRdEn && apicOfs == VECTOR_ENTRY_OFS;
    AST_GP_SET: assert property (badWr |=> gpFault)
        else $error("no fault on non-zero saved-state write");
    AST_GP_CLR: assert property (!badWr |=> !gpFault)
        else $error("fault without non-zero saved-state write");
    AST_CAP: assert property (msrRdEn && msrIdx == GLOBAL_CAP_IDX |=> msrRdValid
        && msrRdData[CAP_TES_BIT] == TES_SUPPORTED && msrRdData[CAP_CTL2_BIT])
        else $error("capability bits wrong");
    AST_RESERVED: assert property (entryRd |=> apicRdValid
        && apicRdData[31:17] == 15'h0 && apicRdData[15:13] == 3'h0 && !apicRdData[11])
        else $error("reserved entry bits not zero");
    AST_ILLEGAL_VEC: assert property (apicWrEn && apicOfs == VECTOR_ENTRY_OFS
        && apicWrData[7:0] < MIN_VECTOR |=> apicErrStatus[6])
        else $error("illegal vector not logged");
    AST_ERR_STICKY: assert property (apicErrStatus[6] |=> apicErrStatus[6])
        else $error("illegal vector flag lost");
    AST_ONE_KIND: assert property ((|nmiReq) |-> !(|fixedReq) && !(|smiReq))
        else $error("more than one delivery kind");
    AST_PULSE: assert property ($rose(|fixedReq) |=> fixedReq == '0 [*3])
        else $error("fixed request repeated before acceptance");
    AST_TARGET: assert property ((|fixedReq) |-> (fixedReq[0] && $onehot(fixedReq))
        || &fixedReq)
        else $error("bad delivery target set");
    AST_RST_QUIET: assert property ($fell(sys_rst) |-> fixedReq == '0 && smiReq == '0
        && nmiReq == '0 && apicErrStatus == 8'h00)
        else $error("activity right after reset");
endmodule

/* File: cerr_core_model.sv */
`timescale 1ns/1ps
module cerr_core_model #(
    parameter int THREADS = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic [THREADS-1:0] fixedReq,
    input wire logic [THREADS-1:0] smiReq,
    input wire logic [THREADS-1:0] nmiReq,
    output logic intAccept
);
    // Slow mode keeps delivery outstanding long enough to be read back
    int waitCnt = 0;
    always @(posedge clk) begin
        intAccept <= 1'b0;
        if (sys_rst) begin
            waitCnt <= 0;
        end else if (|{fixedReq, smiReq, nmiReq}) begin
            waitCnt <= slow ? 12 : 1;
        end else if (waitCnt == 1) begin
            waitCnt <= 0;
            intAccept <= 1'b1;
        end else if (waitCnt > 1) begin
            waitCnt <= waitCnt - 1;
        end
    end
endmodule

/* File: corrected_error_signaling_test.sv */
`timescale 1ns/1ps
module corrected_error_signaling_test;
    import cerr_pkg::*;
    localparam int BANKS = 4;
    localparam int THREADS = 2;
    localparam logic [3:0] CORRECTED_ERROR_INTERRUPT = 4'b0111;
    logic clk = 1'b0, sys_rst = 1'b1, softInit = 1'b0;
    logic msrWrEn = 1'b0, msrRdEn = 1'b0, apicWrEn = 1'b0, apicRdEn = 1'b0;
    logic mcError = 1'b0, repeatLine = 1'b0, healthClear = 1'b0, slow = 1'b0;
    logic [11:0] msrIdx = 12'h0, apicOfs = 12'h2f0;
    logic [63:0] msrWrData = 64'h0, msrRdData, rd, wrVal;
    logic [31:0] apicWrData = 32'h0, apicRdData;
    logic [64*18-1:0] archState = '0;
    logic [BANKS-1:0] countUpdate = '0, sysLevelErr = '0, sharedErr = '0;
    logic [BANKS*15-1:0] errCount = '0;
    logic [BANKS*64-1:0] bankStatus = '0, bankAddr = '0;
    logic intAccept, msrRdValid, gpFault, apicRdValid, healthYellow;
    logic [7:0] apicErrStatus, fixedVector;
    logic [THREADS-1:0] fixedReq, smiReq, nmiReq;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    corrected_error_signaling #(.BANKS(BANKS), .BANK_CORRECTED_ERROR_INTERRUPT(CORRECTED_ERROR_INTERRUPT), .THREADS(THREADS)) dut (.*);
    cerr_core_model #(.THREADS(THREADS)) core (.*);
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic mwr(input logic [11:0] i, input logic [63:0] d);
        @(posedge clk);
        {msrWrEn, msrIdx, msrWrData} <= {1'b1, i, d};
        @(posedge clk);
        msrWrEn <= 1'b0;
        #1;
    endtask
    task automatic mrd(input logic [11:0] i);
        @(posedge clk);
        msrIdx <= i;
        @(posedge clk);
        msrRdEn <= 1'b1;
        @(posedge clk);
        msrRdEn <= 1'b0;
        #1;
        rd = msrRdData;
    endtask
    task automatic awr(input logic [31:0] d);
        @(posedge clk);
        {apicWrEn, apicWrData} <= {1'b1, d};
        @(posedge clk);
        apicWrEn <= 1'b0;
    endtask
    task automatic ard();
        @(posedge clk);
        apicRdEn <= 1'b1;
        @(posedge clk);
        apicRdEn <= 1'b0;
        #1;
        rd = {32'h0, apicRdData};
    endtask
    function automatic logic [3:0] kindOf(input logic [2:0] m);
        return m == MODE_FIXED ? 4'h4 : m == MODE_SMI ? 4'h2 : m == MODE_NMI ? 4'h1 : 4'h0;
    endfunction
    task automatic fire(input int b, input logic [14:0] c, input logic s, input logic h,
                        input logic [3:0] exp);
        logic [3:0] seen;
        seen = 4'h0;
        @(posedge clk);
        {countUpdate, sysLevelErr, sharedErr} <= {4'h1 << b, {4{s}}, {4{h}}};
        errCount <= {4{c}};
        @(posedge clk);
        countUpdate <= '0;
        repeat (10) begin
            @(posedge clk);
            #1;
            seen |= {fixedReq, smiReq[0], nmiReq[0]};
        end
        check(seen, exp);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'he8c2ad6b));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        ard();
        check(rd, VECTOR_ENTRY_RST);
        mrd(BANK_CTL2_BASE);
        check(rd, 64'h0);
        mrd(GLOBAL_CAP_IDX);
        check(rd[11:10], 2'h3);
        check(apicErrStatus[6], 1'b0);
        awr(32'h0001_0005);
        @(posedge clk);
        #1;
        check(apicErrStatus[6], 1'b1);
        $display("test reset done");
        @(posedge clk);
        for (int i = 0; i < 36; i++) archState[i*32+:32] <= $urandom();
        for (int i = 0; i < 8; i++) begin
            {bankStatus[i*32+:32], bankAddr[i*32+:32]} <= {$urandom(), $urandom()};
        end
        mcError <= 1'b1;
        @(posedge clk);
        mcError <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            mrd(SAVE_BASE_IDX + 12'(i));
            check(rd, archState[i*64+:64]);
        end
        @(posedge clk);
        softInit <= 1'b1;
        @(posedge clk);
        softInit <= 1'b0;
        mrd(SAVE_BASE_IDX + 12'h011);
        check(rd, archState[17*64+:64]);
        mwr(SAVE_BASE_IDX, 64'h1);
        check(gpFault, 1'b1);
        mrd(SAVE_BASE_IDX);
        check(rd, archState[63:0]);
        mwr(SAVE_BASE_IDX + 12'h001, 64'h0);
        check(gpFault, 1'b0);
        mrd(SAVE_BASE_IDX + 12'h001);
        check(rd, 64'h0);
        mrd(LEGACY_TYPE_IDX);
        check(rd, bankStatus[63:0]);
        mrd(LEGACY_ADDR_IDX);
        check(rd, bankAddr[63:0]);
        mrd(BANK_STATUS_BASE);
        check(rd, bankStatus[63:0]);
        mrd(BANK_ADDR_BASE);
        check(rd, bankAddr[63:0]);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        mrd(SAVE_BASE_IDX);
        check(rd, 64'h0);
        $display("test saved state done");
        for (int b = 0; b < BANKS; b++) begin
            wrVal = {$urandom(), $urandom()};
            mwr(BANK_CTL2_BASE + 12'(b), wrVal);
            mrd(BANK_CTL2_BASE + 12'(b));
            check(rd, CORRECTED_ERROR_INTERRUPT[b] ? wrVal & 64'h4000_7fff : 64'h0);
        end
        $display("test control done");
        mwr(BANK_CTL2_BASE, 64'h3);
        mwr(BANK_CTL2_BASE + 12'h1, 64'h4000_0003);
        awr(32'h0000_0040);
        fire(0, 15'h3, 1'b0, 1'b0, 4'h0);
        for (int m = 0; m < 8; m++) begin
            awr({21'h0, 3'(m), m == 2 ? 8'h00 : 8'h40});
            fire(1, 15'h3, 1'b0, 1'b0, kindOf(3'(m)));
        end
        awr(32'h0000_0040);
        fire(1, 15'h3, 1'b1, 1'b0, 4'h0);
        fire(1, 15'h2, 1'b0, 1'b0, 4'h0);
        fire(1, 15'h3, 1'b0, 1'b1, 4'hc);
        check(fixedVector, 8'h40);
        slow <= 1'b1;
        fire(1, 15'h3, 1'b0, 1'b0, 4'h4);
        ard();
        check(rd[DSTAT_BIT], 1'b1);
        check(rd[MASK_BIT], 1'b0);
        repeat (20) @(posedge clk);
        ard();
        check(rd[DSTAT_BIT], 1'b0);
        slow <= 1'b0;
        awr(32'h0001_0040);
        fire(1, 15'h3, 1'b0, 1'b0, 4'h0);
        ard();
        check(rd[MASK_BIT], 1'b1);
        $display("test delivery done");
        repeat (4) begin
            @(posedge clk);
            repeatLine <= 1'b1;
            @(posedge clk);
            repeatLine <= 1'b0;
        end
        repeat (2) @(posedge clk);
        #1;
        check(healthYellow, 1'b0);
        @(posedge clk);
        repeatLine <= 1'b1;
        @(posedge clk);
        repeatLine <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(healthYellow, 1'b1);
        @(posedge clk);
        healthClear <= 1'b1;
        @(posedge clk);
        healthClear <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(healthYellow, 1'b0);
        $display("test health done");
        end_of_test();
    end
endmodule
bind corrected_error_signaling cerr_checker #(.TES_SUPPORTED(TES_SUPPORTED), .THREADS(THREADS))
    chk (.*);
